/* src/blind_drive_consts.vh */
`ifndef BLIND_DRIVE_CONSTS_VH
`define BLIND_DRIVE_CONSTS_VH
// ==========================================================
// timing
`define CLK_HZ            40000000
`define MS_CYCLES         (`CLK_HZ / 1000)
`define TRAVEL_S_MIN      15'd1
`define TRAVEL_S_MAX      15'd18000
`define TRAVEL_S_DEF      15'd60
`define REV_MS_MIN        13'd50
`define REV_MS_MAX        13'd5000
`define REV_MS_DEF        13'd700
// ==========================================================
// approach modes
`define APP_DIRECT        2'd0
`define APP_VIA_UP        2'd1
`define APP_VIA_DOWN      2'd2
`define APP_SHORTEST      2'd3
// ==========================================================
// status send policy
`define SEND_UPDATE_ONLY  2'd0
`define SEND_ON_CHANGE    2'd1
`define SEND_ON_REQUEST   2'd2
`define SEND_CHANGE_REQ   2'd3
// ==========================================================
// extra feedback
`define EXTRA_NONE        2'd0
`define EXTRA_ENDS        2'd1
`define EXTRA_BYTE        2'd2
// ==========================================================
// cut-off modes: 0..4 end position + 0/2/5/10/20 %, 5 full time + 10 %
`define CUT_END_0         3'd0
`define CUT_END_2         3'd1
`define CUT_END_5         3'd2
`define CUT_END_10        3'd3
`define CUT_END_20        3'd4
`define CUT_FULL_10       3'd5
// ==========================================================
// position scale
`define POS_UP            8'h00
`define POS_DOWN          8'hff
// status byte bit positions
`define SB_UPPER          0
`define SB_LOWER          1
`define SB_MOVING_UP      2
`define SB_MOVING_DOWN    3
`define SB_REVERSING      4
`endif

/* src/blind_drive_positioner.v */
// Behaviour
// - direct mode drives straight to target
// - via-up/down visits chosen end first
// - shortest mode visits nearer end first
// - feedback enabled keeps current position status
// - send policy: update, change, request, both
// - end feedback drives upper/lower limit flags
// - status byte replaces flags; none gives nothing
// - travel time 1..18000 s bases estimate
// - direction change holds both relays off
// - end cut-off: remaining time plus overflow
// - full-time cut-off: total time plus ten percent
`include "blind_drive_consts.vh"
module blind_drive_positioner
(
	input  wire        i_clk,          // 40 MHz system clock
	input  wire        i_rst_n,        // asynchronous reset, active low
	input  wire        i_pos_cmd,      // one-cycle pulse: new target position
	input  wire [7:0]  i_pos_target,   // target, 0 up .. 255 down
	input  wire        i_stop_cmd,     // one-cycle pulse: stop now
	input  wire        i_status_req,   // one-cycle pulse: status read request
	input  wire [1:0]  i_approach,     // approach mode
	input  wire        i_fb_enable,    // position feedback enabled
	input  wire [1:0]  i_send_mode,    // status send policy
	input  wire [1:0]  i_extra_fb,     // extra feedback selection
	input  wire [14:0] i_travel_s,     // total travel time in seconds
	input  wire [12:0] i_reverse_ms,   // reversing pause in ms
	input  wire [2:0]  i_cutoff,       // cut-off mode
	output wire        o_relay_up,     // motor up relay
	output wire        o_relay_down,   // motor down relay
	output reg  [7:0]  o_pos_status,   // current position status value
	output reg         o_pos_send,     // one-cycle pulse: transmit status
	output reg         o_upper_end,    // upper end reached flag
	output reg         o_lower_end,    // lower end reached flag
	output reg  [7:0]  o_status_byte,  // coded status byte
	output reg         o_status_byte_en // status byte enabled
);
	// ==========================================================
	// reset synchroniser
	reg rst_s1_q;
	reg rst_q;
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rst_s1_q <= 1'b0;
			rst_q    <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_q    <= rst_s1_q;
		end
	end
	wire rst_n = rst_q;

	// ==========================================================
	// configuration clamp
	wire [14:0] travel_s = (i_travel_s < `TRAVEL_S_MIN) ? `TRAVEL_S_MIN :
		(i_travel_s > `TRAVEL_S_MAX) ? `TRAVEL_S_MAX : i_travel_s;
	wire [12:0] rev_ms = (i_reverse_ms < `REV_MS_MIN) ? `REV_MS_MIN :
		(i_reverse_ms > `REV_MS_MAX) ? `REV_MS_MAX : i_reverse_ms;

	// ==========================================================
	// position tick: one step of 1/255 travel per tick
	// tick period = travel_s * 40e6 / 255 cycles; the product needs 40 bits at
	// 18000 s, so it is formed wide; the quotient fits 32 bits (<= 2.83e9)
	wire [47:0] step_prod   = travel_s * 48'h0000_0262_5a00;
	wire [47:0] step_quot   = step_prod / 48'h0000_0000_00ff;
	wire [31:0] step_cycles = step_quot[31:0];
	wire [31:0] ms_cycles   = `MS_CYCLES;
	reg  [31:0] step_cnt_q;
	reg  [7:0]  pos_q;      // time-based estimate
	reg  [7:0]  frac_q;     // unused, held at zero from reset

	localparam [5:0] ST_IDLE    = 6'b000001;
	localparam [5:0] ST_PAUSE   = 6'b000010;
	localparam [5:0] ST_UP      = 6'b000100;
	localparam [5:0] ST_DOWN    = 6'b001000;
	localparam [5:0] ST_OVER    = 6'b010000;
	localparam [5:0] ST_SPARE   = 6'b100000;

	reg [5:0]  state_q;
	reg        dir_down_q;   // direction of the current or pending move
	reg        last_down_q;  // direction last energised
	reg        ran_q;        // a direction was energised since reset
	reg [7:0]  goal_q;       // present leg target
	reg [7:0]  final_q;      // final commanded target
	reg        via_q;        // an end leg precedes the final leg
	reg [7:0]  over_q;       // overflow steps still to drive
	reg [7:0]  over_lim_q;   // overflow steps for this end move
	reg [31:0] pause_q;      // reversing pause cycles elapsed
	reg        full_q;       // full-time end move in progress
	reg [8:0]  full_steps_q; // steps left for a full-time move

	// overflow in steps of 1/255 travel
	function [7:0] over_steps;
		input [2:0] mode;
		begin
			case (mode)
				`CUT_END_2:   over_steps = 8'h05;
				`CUT_END_5:   over_steps = 8'h0d;
				`CUT_END_10:  over_steps = 8'h1a;
				`CUT_END_20:  over_steps = 8'h33;
				default:      over_steps = 8'h00;
			endcase
		end
	endfunction

	wire is_end_goal = (goal_q == `POS_UP) || (goal_q == `POS_DOWN);
	wire full_mode   = (i_cutoff == `CUT_FULL_10);
	wire step_tick   = (step_cnt_q >= step_cycles - 32'd1);
	wire near_down   = (pos_q > 8'h7f);

	// leg start: returns true when the move needs a reversing pause first
	wire need_pause = ran_q && (dir_down_q != last_down_q);

	// ==========================================================
	// motion sequencer
	always @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q      <= ST_IDLE;
			dir_down_q   <= 1'b0;
			last_down_q  <= 1'b0;
			ran_q        <= 1'b0;
			goal_q       <= `POS_UP;
			final_q      <= `POS_UP;
			via_q        <= 1'b0;
			over_q       <= 8'h00;
			over_lim_q   <= 8'h00;
			pause_q      <= 32'h0;
			step_cnt_q   <= 32'h0;
			pos_q        <= `POS_UP;
			frac_q       <= 8'h00;
			full_q       <= 1'b0;
			full_steps_q <= 9'h000;
		end
		else if (i_stop_cmd)
		begin
			// stop drops both relays this same edge; a later move still pauses
			state_q    <= ST_IDLE;
			step_cnt_q <= 32'h0;
			via_q      <= 1'b0;
			full_q     <= 1'b0;
		end
		else if (i_pos_cmd)
		begin
			final_q    <= i_pos_target;
			step_cnt_q <= 32'h0;
			case (i_approach)
				`APP_VIA_UP:
				begin
					goal_q <= `POS_UP;
					via_q  <= 1'b1;
				end
				`APP_VIA_DOWN:
				begin
					goal_q <= `POS_DOWN;
					via_q  <= 1'b1;
				end
				`APP_SHORTEST:
				begin
					goal_q <= near_down ? `POS_DOWN : `POS_UP;
					via_q  <= 1'b1;
				end
				default:
				begin
					goal_q <= i_pos_target;
					via_q  <= 1'b0;
				end
			endcase
			state_q <= ST_SPARE;   // evaluate the leg next cycle
		end
		else
		begin
			case (state_q)
				ST_SPARE:
				begin
					// leg start: pick direction, load cut-off budget
					full_q       <= full_mode && is_end_goal;
					full_steps_q <= 9'd255 + 9'd26; // 255 steps + 10 %
					over_lim_q   <= is_end_goal ? over_steps(i_cutoff) : 8'h00;
					over_q       <= is_end_goal ? over_steps(i_cutoff) : 8'h00;
					if (goal_q == pos_q && !(full_mode && is_end_goal))
					begin
						if (is_end_goal && over_steps(i_cutoff) != 8'h00)
						begin
							dir_down_q <= (goal_q == `POS_DOWN);
							state_q    <= ST_PAUSE;
						end
						else if (via_q)
						begin
							via_q   <= 1'b0;
							goal_q  <= final_q;
						end
						else
							state_q <= ST_IDLE;
					end
					else
					begin
						dir_down_q <= (goal_q == `POS_DOWN) ? 1'b1 :
							(goal_q == `POS_UP) ? 1'b0 : (goal_q > pos_q);
						state_q    <= ST_PAUSE;
					end
					pause_q <= 32'h0;
				end
				ST_PAUSE:
				begin
					if (need_pause && pause_q < rev_ms * ms_cycles)
						pause_q <= pause_q + 32'd1; // both relays off
					else
					begin
						last_down_q <= dir_down_q;
						ran_q       <= 1'b1;
						state_q     <= dir_down_q ? ST_DOWN : ST_UP;
					end
				end
				ST_UP, ST_DOWN:
				begin
					if (step_tick)
					begin
						step_cnt_q <= 32'h0;
						if (full_q)
							full_steps_q <= full_steps_q - 9'd1;
						if (dir_down_q && pos_q != `POS_DOWN)
							pos_q <= pos_q + 8'd1;
						else if (!dir_down_q && pos_q != `POS_UP)
							pos_q <= pos_q - 8'd1;
					end
					else
						step_cnt_q <= step_cnt_q + 32'd1;
					if (full_q)
					begin
						if (full_steps_q == 9'h000)
						begin
							full_q  <= 1'b0;
							state_q <= via_q ? ST_SPARE : ST_IDLE;
							if (via_q)
								goal_q <= final_q;
							via_q   <= 1'b0;
						end
					end
					else if (pos_q == goal_q)
					begin
						if (is_end_goal && over_q != 8'h00)
							state_q <= ST_OVER;
						else
						begin
							state_q <= via_q ? ST_SPARE : ST_IDLE;
							if (via_q)
								goal_q <= final_q;
							via_q   <= 1'b0;
						end
					end
				end
				ST_OVER:
				begin
					if (step_tick)
					begin
						step_cnt_q <= 32'h0;
						over_q     <= over_q - 8'd1;
						if (over_q == 8'd1)
						begin
							state_q <= via_q ? ST_SPARE : ST_IDLE;
							if (via_q)
								goal_q <= final_q;
							via_q   <= 1'b0;
						end
					end
					else
						step_cnt_q <= step_cnt_q + 32'd1;
				end
				default:
					state_q <= state_q;
			endcase
		end
	end

	// ==========================================================
	// relays: one direction at a time by construction
	wire drive = (state_q == ST_UP) || (state_q == ST_DOWN) || (state_q == ST_OVER);
	assign o_relay_up   = drive && !dir_down_q && !i_stop_cmd;
	assign o_relay_down = drive &&  dir_down_q && !i_stop_cmd;

	// ==========================================================
	// feedback
	always @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_pos_status     <= `POS_UP;
			o_pos_send       <= 1'b0;
			o_upper_end      <= 1'b0;
			o_lower_end      <= 1'b0;
			o_status_byte    <= 8'h00;
			o_status_byte_en <= 1'b0;
		end
		else
		begin
			o_pos_send <= 1'b0;
			if (i_fb_enable)
			begin
				o_pos_status <= pos_q;
				case (i_send_mode)
					`SEND_ON_CHANGE:
						o_pos_send <= (pos_q != o_pos_status);
					`SEND_ON_REQUEST:
						o_pos_send <= i_status_req;
					`SEND_CHANGE_REQ:
						o_pos_send <= (pos_q != o_pos_status) || i_status_req;
					default:
						o_pos_send <= 1'b0;
				endcase
			end
			o_upper_end <= (i_extra_fb == `EXTRA_ENDS) && (pos_q == `POS_UP);
			o_lower_end <= (i_extra_fb == `EXTRA_ENDS) && (pos_q == `POS_DOWN);
			o_status_byte_en <= (i_extra_fb == `EXTRA_BYTE);
			if (i_extra_fb == `EXTRA_BYTE)
			begin
				o_status_byte <= 8'h00;
				o_status_byte[`SB_UPPER]       <= (pos_q == `POS_UP);
				o_status_byte[`SB_LOWER]       <= (pos_q == `POS_DOWN);
				o_status_byte[`SB_MOVING_UP]   <= o_relay_up;
				o_status_byte[`SB_MOVING_DOWN] <= o_relay_down;
				o_status_byte[`SB_REVERSING]   <= (state_q == ST_PAUSE);
			end
			else
				o_status_byte <= 8'h00;
		end
	end
endmodule // blind_drive_positioner

/* tb/blind_drive_checker_assertions.sv */
// ==========================================================
// port checks for the blind positioner
module blind_drive_checker (
	input logic       i_clk,           // clock
	input logic       i_rst_n,         // reset, low
	input logic       i_stop_cmd,      // stop pulse
	input logic       i_status_req,    // status request
	input logic       i_fb_enable,     // feedback on
	input logic [1:0] i_send_mode,     // send policy
	input logic [1:0] i_extra_fb,      // extra feedback
	input logic       o_relay_up,      // up relay
	input logic       o_relay_down,    // down relay
	input logic [7:0] o_pos_status,    // position
	input logic       o_pos_send,      // send pulse
	input logic       o_upper_end,     // upper flag
	input logic       o_lower_end,     // lower flag
	input logic [7:0] o_status_byte,   // status byte
	input logic       o_status_byte_en // byte enable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] live_q;
	// outputs lag the release by the two sync flops and their own register stage
	always @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n)
			live_q <= 3'h0;
		else if (live_q != 3'h4)
			live_q <= live_q + 3'h1;
	default clocking @(posedge i_clk); endclocking
	default disable iff (live_q != 3'h4);
	// ==========================================================
	// assertions
	a_relays_exclusive: assert property (!(o_relay_up && o_relay_down))
		else $error("both relays on");
	a_stop_drops: assert property (i_stop_cmd |-> !o_relay_up && !o_relay_down)
		else $error("relay on during stop");
	a_byte_enable: assert property (o_status_byte_en == $past(i_extra_fb == 2'h2))
		else $error("status byte enable wrong");
	a_byte_blank: assert property (!o_status_byte_en |-> o_status_byte == 8'h00)
		else $error("status byte without enable");
	a_ends_gated: assert property ($past(i_extra_fb) != 2'h1 |-> !o_upper_end && !o_lower_end)
		else $error("end flag while not selected");
	a_ends_apart: assert property (!(o_upper_end && o_lower_end))
		else $error("both end flags set");
	a_pos_frozen: assert property (!$past(i_fb_enable) |-> $stable(o_pos_status))
		else $error("position status moved while disabled");
	a_send_silent: assert property ($past(i_send_mode) == 2'h0 |-> !o_pos_send)
		else $error("status sent in update-only mode");
	a_send_request: assert property (i_status_req && i_fb_enable && i_send_mode == 2'h2
		|-> ##[1:3] o_pos_send)
		else $error("no send after request");
	c_move_down: cover property (o_relay_down);
	c_reversing: cover property (o_status_byte_en && o_status_byte[4]);
	c_move_up: cover property (o_relay_up);
	c_send: cover property (o_pos_send);
endmodule // blind_drive_checker

/* tb/shutter_motor_model.sv */
// ==========================================================
// motor behind the relays, flags bad relay use
module shutter_motor_model #(
	parameter int PAUSE_CYC = 2000000 // 50 ms at 40 MHz
) (
	input  wire logic i_clk,   // system clock
	input  wire logic i_rst_n, // reset, low
	input  wire logic i_up,    // up relay coil
	input  wire logic i_down,  // down relay coil
	output logic      o_fault  // breach seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] off_q = '0;
	logic        dir_q = 1'h0; // high when last run was down
	logic        ran_q = 1'h0;
	initial o_fault = 1'h0;
	// the block forgets its last direction in reset, so the model does too
	always @(posedge i_clk)
	begin
		if (i_up && i_down)
			o_fault <= 1'h1;
		if (!i_rst_n)
			ran_q <= 1'h0;
		else if (i_up || i_down)
		begin
			if (ran_q && i_down != dir_q && off_q < PAUSE_CYC)
				o_fault <= 1'h1;
			ran_q <= 1'h1;
			dir_q <= i_down;
			off_q <= '0;
		end
		else
			off_q <= off_q + 1;
	end
endmodule // shutter_motor_model

/* tb/blind_drive_positioner_tb.sv */
`include "blind_drive_consts.vh"
// ==========================================================
// bench
module blind_drive_positioner_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk = 1'h0, i_rst_n = 1'h0, i_pos_cmd = 1'h0;
	logic        i_stop_cmd = 1'h0, i_status_req = 1'h0, i_fb_enable = 1'h0;
	logic [1:0]  i_approach = '0, i_send_mode = '0, i_extra_fb = '0;
	logic [7:0]  i_pos_target = '0;
	logic [14:0] i_travel_s = 15'h0001;
	logic [12:0] i_reverse_ms = 13'h0032;
	logic [2:0]  i_cutoff = '0;
	wire         o_relay_up, o_relay_down, o_pos_send, o_upper_end, o_lower_end;
	wire         o_status_byte_en, fault;
	wire  [7:0]  o_pos_status, o_status_byte;
	int          failures = 0, n_tests = 0, cyc = 0, sends = 0, s0;
	logic [14:0] rows [8];
	blind_drive_positioner blind_drive_positioner_i (.i_clk, .i_rst_n, .i_pos_cmd,
		.i_pos_target, .i_stop_cmd, .i_status_req, .i_approach, .i_fb_enable, .i_send_mode,
		.i_extra_fb, .i_travel_s, .i_reverse_ms, .i_cutoff, .o_relay_up, .o_relay_down,
		.o_pos_status, .o_pos_send, .o_upper_end, .o_lower_end, .o_status_byte,
		.o_status_byte_en);
	shutter_motor_model shutter_motor_model_i (.i_clk, .i_rst_n, .i_up(o_relay_up),
		.i_down(o_relay_down), .o_fault(fault));
	initial forever #12.5 i_clk = ~i_clk;
	always @(posedge i_clk)
	begin
		sends += int'(o_pos_send === 1'h1);
		cyc++;
		if (cyc == 3000)
		begin
			failures++;
			test_done();
		end
	end
	task automatic chk_relay(input logic eu, input logic ed);
		n_tests++;
		if (o_relay_up !== eu || o_relay_down !== ed)
		begin
			failures++;
			$display("MISMATCH %0t relays %b%b", $time, o_relay_up, o_relay_down);
		end
	endtask
	task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic reset_dut();
		@(posedge i_clk);
		i_rst_n <= 1'h0;
		repeat (11) @(posedge i_clk);
		#1 chk_relay(1'h0, 1'h0);
		chk_bits(o_pos_status, `POS_UP);
		@(posedge i_clk);
		i_rst_n <= 1'h1;
		repeat (3) @(posedge i_clk);
	endtask
	task automatic ask(input logic [1:0] mode);
		@(posedge i_clk);
		i_send_mode <= mode;
		s0 = sends;
		i_status_req <= 1'h1;
		@(posedge i_clk);
		i_status_req <= 1'h0;
		step(4);
	endtask
	task automatic test_done();
		if (failures == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==========================================================
	// table: mode, cut-off, target, then up and down soon after
	initial
	begin
		rows[0] = {`APP_DIRECT, `CUT_END_0, 8'h0a, 2'h1};
		rows[1] = {`APP_DIRECT, `CUT_END_0, 8'h00, 2'h0};
		rows[2] = {`APP_VIA_DOWN, `CUT_END_0, 8'h00, 2'h1};
		rows[3] = {`APP_DIRECT, `CUT_END_20, 8'hff, 2'h1};
		rows[4] = {`APP_DIRECT, `CUT_FULL_10, 8'h00, 2'h2};
		rows[5] = {`APP_VIA_UP, `CUT_FULL_10, 8'h00, 2'h2};
		rows[6] = {`APP_SHORTEST, `CUT_END_0, 8'h80, 2'h1};
		rows[7] = {`APP_VIA_UP, `CUT_END_20, 8'h80, 2'h2};
		foreach (rows[k])
		begin
			reset_dut();
			{i_approach, i_cutoff, i_pos_target} <= rows[k][14:2];
			i_pos_cmd <= 1'h1;
			@(posedge i_clk);
			i_pos_cmd <= 1'h0;
			step(6);
			chk_relay(rows[k][1], rows[k][0]);
		end
		// ==========================================================
		// stop during the overflow past the upper end, then reverse: the pause must keep both off
		@(posedge i_clk);
		i_stop_cmd <= 1'h1;
		#1 chk_relay(1'h0, 1'h0);
		@(posedge i_clk);
		i_stop_cmd <= 1'h0;
		{i_approach, i_cutoff, i_pos_target} <= {`APP_DIRECT, `CUT_END_0, 8'hff};
		i_extra_fb <= `EXTRA_BYTE;
		i_pos_cmd <= 1'h1;
		@(posedge i_clk);
		i_pos_cmd <= 1'h0;
		repeat (1000)
		begin
			step(1);
			chk_relay(1'h0, 1'h0);
		end
		chk_bits(o_status_byte, (8'h01 << `SB_UPPER) | (8'h01 << `SB_REVERSING));
		// ==========================================================
		// feedback selections and status requests
		reset_dut();
		i_extra_fb <= 2'h1;
		i_fb_enable <= 1'h1;
		i_send_mode <= `SEND_ON_REQUEST;
		step(3);
		chk_bits({5'h0, o_upper_end, o_lower_end, o_status_byte_en}, 8'h04);
		@(posedge i_clk);
		i_extra_fb <= 2'h2;
		s0 = sends;
		i_status_req <= 1'h1;
		@(posedge i_clk);
		i_status_req <= 1'h0;
		step(4);
		chk_bits(8'(sends - s0), 8'h01);
		chk_bits(o_status_byte, 8'h01 << `SB_UPPER);
		chk_bits({5'h0, o_upper_end, o_lower_end, o_status_byte_en}, 8'h01);
		chk_bits(o_pos_status, `POS_UP);
		@(posedge i_clk);
		i_send_mode <= `SEND_UPDATE_ONLY;
		i_extra_fb <= 2'h0;
		s0 = sends;
		i_status_req <= 1'h1;
		@(posedge i_clk);
		i_status_req <= 1'h0;
		step(4);
		chk_bits(8'(sends - s0), 8'h00);
		chk_bits({o_status_byte[6:0], o_status_byte_en}, 8'h00);
		ask(`SEND_CHANGE_REQ);
		chk_bits(8'(sends - s0), 8'h01);
		ask(`SEND_ON_CHANGE);
		chk_bits(8'(sends - s0), 8'h00);
		chk_bits({7'h0, fault}, 8'h00);
		test_done();
	end
endmodule // blind_drive_positioner_tb
bind blind_drive_positioner blind_drive_checker blind_drive_checker_i (.i_clk, .i_rst_n,
	.i_stop_cmd, .i_status_req, .i_fb_enable, .i_send_mode, .i_extra_fb, .o_relay_up,
	.o_relay_down, .o_pos_status, .o_pos_send, .o_upper_end, .o_lower_end, .o_status_byte,
	.o_status_byte_en);
